// ===== logic/ccr_regs.sv
// crate controller control registers: action strobes and the station-25 register file
// assumes commands arrive as one-cycle valid pulses synchronous to clk_i
`timescale 1ns/1ns
module ccr_regs #(
    parameter logic [15:0] FW_ID          = ccr_pkg::FW_ID_DEFAULT, // arbitrary value
    parameter int          SW_TRIG_CYCLES = ccr_pkg::SW_TRIG_CYCLES,
    parameter int          US_CYCLES      = ccr_pkg::US_CYCLES
) (
    input  wire logic                clk_i,
    input  wire logic                rst_b_i,
    input  wire logic                direct_wr_i,
    input  wire logic                direct_rd_i,
    input  wire logic [2:0]          direct_target_i,
    input  wire logic [15:0]         direct_wdata_i,
    input  wire logic                cmd_valid_i,
    input  wire ccr_pkg::ccr_cmd_t   cmd_i,
    input  wire logic [23:0]         lam_lines_i,
    input  wire logic [31:0]         counter_a_i,
    input  wire logic [31:0]         counter_b_i,
    input  wire logic [23:0]         notepad_map_i,
    input  wire logic                user_input_1_i,
    input  wire logic                scaler_stack_ready_i,
    output logic                     direct_rd_valid_o,
    output logic [15:0]              direct_rdata_o,
    output ccr_pkg::ccr_rsp_t        rsp_o,
    output logic                     acquire_o,
    output logic                     sw_trigger_o,
    output logic                     clear_o,
    output logic                     scaler_dump_o,
    output logic                     event_start_o,
    output ccr_pkg::ccr_bufcfg_t     buf_cfg_o,
    output ccr_pkg::ccr_aux_t        aux_o
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic                 acq;
        logic [7:0]           trig_cnt;
        logic                 trig;
        logic                 clear;
        logic                 dump;
        logic [15:0]          gmode;
        logic [15:0]          delays;
        logic [23:0]          lam_enable_mask;
        ccr_pkg::ccr_aux_t    aux;
        ccr_pkg::ccr_rsp_t    rsp;
        logic                 drd_valid;
        logic [15:0]          drdata;
        logic                 in1_prev;
        logic                 lam_hit_prev;
        logic                 event_start;
        ccr_pkg::ccr_bufcfg_t bcfg;
    } ccr_state_t;

    ccr_state_t s_q;
    ccr_state_t s_d;

    logic dly_start;
    logic dly_done;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // one decode shared by read and write paths
    function automatic logic is_own(input ccr_pkg::ccr_cmd_t c, input logic [4:0] f);
        is_own = (c.station == ccr_pkg::STATION_OWN) && (c.func == f);
    endfunction : is_own

    // true for sub-addresses that software may store into
    function automatic logic is_writable(input logic [3:0] a);
        is_writable = !(a == ccr_pkg::SUB_FW_ID || a == ccr_pkg::SUB_LAM_VIEW ||
                        a == ccr_pkg::SUB_CNT_A || a == ccr_pkg::SUB_CNT_B ||
                        a == ccr_pkg::SUB_NOTEPAD);
    endfunction : is_writable

    // read multiplexer, pseudo-registers come straight from live inputs
    function automatic logic [31:0] read_sub(input ccr_state_t s, input logic [3:0] a,
                                            input logic [23:0] lam, input logic [31:0] ca,
                                            input logic [31:0] cb, input logic [23:0] np);
        read_sub = 32'h00000000;
        unique case (a)
            ccr_pkg::SUB_FW_ID:    read_sub = {16'h0000, FW_ID};
            ccr_pkg::SUB_GMODE:    read_sub = {16'h0000, s.gmode};
            ccr_pkg::SUB_DELAYS:   read_sub = {16'h0000, s.delays};
            ccr_pkg::SUB_SCLR_CTL: read_sub = {8'h00, s.aux.scaler_dump_control};
            ccr_pkg::SUB_LED_SEL:  read_sub = s.aux.indicator_source_select;
            ccr_pkg::SUB_OUT_SEL:  read_sub = s.aux.output_source_select;
            ccr_pkg::SUB_UDEV_SEL: read_sub = s.aux.user_device_source_select;
            ccr_pkg::SUB_DGG_A:    read_sub = s.aux.pulse_generator_a_timing;
            ccr_pkg::SUB_DGG_B:    read_sub = s.aux.pulse_generator_b_timing;
            ccr_pkg::SUB_LAM_ENABLE_MASK: read_sub = {8'h00, s.lam_enable_mask};
            ccr_pkg::SUB_LAM_VIEW: read_sub = {8'h00, lam};
            ccr_pkg::SUB_CNT_A:    read_sub = ca;
            ccr_pkg::SUB_CNT_B:    read_sub = cb;
            ccr_pkg::SUB_EXT_DLY:  read_sub = s.aux.coarse_delay_extension;
            ccr_pkg::SUB_USB_SET:  read_sub = s.aux.host_buffering_setup;
            ccr_pkg::SUB_NOTEPAD:  read_sub = {8'h00, np};
        endcase
    endfunction : read_sub

    // decoded buffer configuration derived from global mode and delays
    function automatic ccr_pkg::ccr_bufcfg_t decode_cfg(input logic [15:0] gm,
                                                         input logic [15:0] dl);
        logic [2:0] len;
        len = gm[ccr_pkg::GM_LEN_LSB +: 3];
        decode_cfg = '0;
        decode_cfg.single_event         = (len == ccr_pkg::LEN_SINGLE_EVENT);
        decode_cfg.buffer_length_words  = (len == ccr_pkg::LEN_SINGLE_EVENT) ? 13'h0000 :
                                          (ccr_pkg::LEN_MAX_WORDS >> len);
        decode_cfg.spill_across         = gm[ccr_pkg::GM_SPILL_BIT];
        decode_cfg.shared_buffer_enable = gm[ccr_pkg::GM_SHARED_BIT];
        decode_cfg.terminator_count     = gm[ccr_pkg::GM_TERM_BIT] ? 2'h2 : 2'h1;
        decode_cfg.header_words         = gm[ccr_pkg::GM_HDR_BIT] ? 2'h2 : 2'h1;
        decode_cfg.arbitration_enable   = gm[ccr_pkg::GM_ARB_BIT];
        decode_cfg.lam_timeout_us       = dl[ccr_pkg::DLY_LAM_LSB +: 8];
    endfunction : decode_cfg

    // ------------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------------
    // strobes last one cycle except the software trigger, which is stretched
    always_comb begin
        logic act_wr;
        logic lam_hit;
        logic in1_rise;
        act_wr   = 1'b0;
        lam_hit  = 1'b0;
        in1_rise = 1'b0;
        s_d      = s_q;

        s_d.clear       = 1'b0;
        s_d.dump        = 1'b0;
        s_d.event_start = 1'b0;
        s_d.rsp.valid   = 1'b0;
        s_d.drd_valid   = 1'b0;

        // only target one is a register; the others belong to stacks, the command generator and the output buffer
        act_wr = direct_wr_i && (direct_target_i == ccr_pkg::TGT_REG_BLOCK);

        // software trigger stretch counter
        if (s_q.trig_cnt != 8'h00) begin
            s_d.trig_cnt = s_q.trig_cnt - 8'h01;
        end
        if (act_wr && direct_wdata_i[ccr_pkg::ACT_TRIG_BIT]) begin
            s_d.trig_cnt = 8'(SW_TRIG_CYCLES);
        end
        s_d.trig = (s_d.trig_cnt != 8'h00);

        // action register, only the start bit is stored
        if (act_wr) begin
            s_d.acq  = direct_wdata_i[ccr_pkg::ACT_START_BIT];
            // dump needs acquisition kept on by the same write, hence the value 17
            s_d.dump = direct_wdata_i[ccr_pkg::ACT_DUMP_BIT] &&
                       direct_wdata_i[ccr_pkg::ACT_START_BIT] && s_q.acq &&
                       scaler_stack_ready_i;
        end

        // direct read returns the stored start bit, strobe bits read zero
        if (direct_rd_i) begin
            s_d.drd_valid = 1'b1;
            s_d.drdata    = (direct_target_i == ccr_pkg::TGT_REG_BLOCK) ?
                            {15'h0000, s_q.acq} : 16'h0000;
        end

        // station commands: read and write of the register file
        if (cmd_valid_i) begin
            s_d.rsp.valid = 1'b1;
            s_d.rsp.q     = 1'b0;
            s_d.rsp.x     = 1'b0;
            s_d.rsp.rdata = 32'h00000000;
            if (is_own(cmd_i, ccr_pkg::FUNC_READ)) begin
                s_d.rsp.q     = 1'b1;
                s_d.rsp.x     = 1'b1;
                s_d.rsp.rdata = read_sub(s_q, cmd_i.subaddr, lam_lines_i, counter_a_i,
                                         counter_b_i, notepad_map_i);
            end else if (is_own(cmd_i, ccr_pkg::FUNC_WRITE)) begin
                s_d.rsp.x = 1'b1;
                s_d.rsp.q = is_writable(cmd_i.subaddr);
                unique case (cmd_i.subaddr)
                    ccr_pkg::SUB_GMODE:    s_d.gmode = cmd_i.wdata[15:0];
                    ccr_pkg::SUB_DELAYS:   s_d.delays = cmd_i.wdata[15:0];
                    ccr_pkg::SUB_SCLR_CTL: s_d.aux.scaler_dump_control = cmd_i.wdata[23:0];
                    ccr_pkg::SUB_LED_SEL:  s_d.aux.indicator_source_select = cmd_i.wdata;
                    ccr_pkg::SUB_OUT_SEL:  s_d.aux.output_source_select = cmd_i.wdata;
                    ccr_pkg::SUB_UDEV_SEL: s_d.aux.user_device_source_select = cmd_i.wdata;
                    ccr_pkg::SUB_DGG_A:    s_d.aux.pulse_generator_a_timing = cmd_i.wdata;
                    ccr_pkg::SUB_DGG_B:    s_d.aux.pulse_generator_b_timing = cmd_i.wdata;
                    ccr_pkg::SUB_LAM_ENABLE_MASK: s_d.lam_enable_mask = cmd_i.wdata[23:0];
                    ccr_pkg::SUB_EXT_DLY:  s_d.aux.coarse_delay_extension = cmd_i.wdata;
                    ccr_pkg::SUB_USB_SET:  s_d.aux.host_buffering_setup = cmd_i.wdata;
                    default:               s_d.gmode = s_q.gmode; // read-only, ignored
                endcase
            end
        end

        // clear wins over any register write in the same cycle
        if (act_wr && direct_wdata_i[ccr_pkg::ACT_CLEAR_BIT]) begin
            s_d.clear    = 1'b1;
            s_d.acq      = 1'b0;
            s_d.gmode    = ccr_pkg::RST_GMODE;
            s_d.delays   = ccr_pkg::RST_DELAYS;
            s_d.lam_enable_mask = ccr_pkg::RST_W24;
            s_d.aux      = '0;
            s_d.trig_cnt = 8'h00;
            s_d.trig     = 1'b0;
            s_d.dump     = 1'b0;
        end

        // event triggering, edges so a held level starts only one readout
        s_d.in1_prev     = user_input_1_i;
        lam_hit          = |(lam_lines_i & s_q.lam_enable_mask);
        s_d.lam_hit_prev = lam_hit;
        in1_rise         = user_input_1_i && !s_q.in1_prev;
        if (s_q.acq && lam_hit && !s_q.lam_hit_prev) begin
            s_d.event_start = 1'b1;
        end
        if (dly_done && s_q.acq) begin
            s_d.event_start = 1'b1;
        end
        dly_start = s_q.acq && in1_rise;

        s_d.bcfg = decode_cfg(s_d.gmode, s_d.delays);
    end

    // ------------------------------------------------------------------
    // trigger delay from start input to readout
    // ------------------------------------------------------------------
    ccr_us_delay #(
        .US_CYCLES (US_CYCLES)
    ) u_trig_delay (
        .clk_i      (clk_i),
        .rst_b_i    (rst_b_i),
        .start_i    (dly_start),
        .delay_us_i (s_q.delays[ccr_pkg::DLY_TRIG_LSB +: 8]),
        .busy_o     (),
        .done_o     (dly_done)
    );

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s_q        <= '0;
            s_q.bcfg   <= decode_cfg(ccr_pkg::RST_GMODE, ccr_pkg::RST_DELAYS);
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------
    // outputs, all straight from the state register
    // ------------------------------------------------------------------
    assign direct_rd_valid_o = s_q.drd_valid;
    assign direct_rdata_o    = s_q.drdata;
    assign rsp_o             = s_q.rsp;
    assign acquire_o         = s_q.acq;
    assign sw_trigger_o      = s_q.trig;
    assign clear_o           = s_q.clear;
    assign scaler_dump_o     = s_q.dump;
    assign event_start_o     = s_q.event_start;
    assign buf_cfg_o         = s_q.bcfg;
    assign aux_o             = s_q.aux;

endmodule : ccr_regs

// ===== pkg/ccr_pkg.sv
// constants, field layouts and carrier types of the crate controller register set
// assumes a single 100 MHz clock shared by every file that uses it
package ccr_pkg;

    // ------------------------------------------------------------------
    // internal targets and command decoding
    // ------------------------------------------------------------------
    localparam logic [2:0] TGT_REG_BLOCK   = 3'h1;
    localparam logic [2:0] TGT_DATA_STACK  = 3'h2;
    localparam logic [2:0] TGT_SCLR_STACK  = 3'h3;
    localparam logic [2:0] TGT_CMD_GEN     = 3'h4;
    localparam logic [2:0] TGT_OUT_BUFFER  = 3'h5;
    localparam logic [4:0] STATION_OWN     = 5'h19;
    localparam logic [4:0] FUNC_READ       = 5'h00;
    localparam logic [4:0] FUNC_WRITE      = 5'h10;

    // ------------------------------------------------------------------
    // action strobe bit positions
    // ------------------------------------------------------------------
    localparam int ACT_START_BIT = 0;
    localparam int ACT_TRIG_BIT  = 1;
    localparam int ACT_CLEAR_BIT = 2;
    localparam int ACT_SPARE_BIT = 3;
    localparam int ACT_DUMP_BIT  = 4;

    // ------------------------------------------------------------------
    // register file sub-addresses
    // ------------------------------------------------------------------
    localparam logic [3:0] SUB_FW_ID    = 4'h0;
    localparam logic [3:0] SUB_GMODE    = 4'h1;
    localparam logic [3:0] SUB_DELAYS   = 4'h2;
    localparam logic [3:0] SUB_SCLR_CTL = 4'h3;
    localparam logic [3:0] SUB_LED_SEL  = 4'h4;
    localparam logic [3:0] SUB_OUT_SEL  = 4'h5;
    localparam logic [3:0] SUB_UDEV_SEL = 4'h6;
    localparam logic [3:0] SUB_DGG_A    = 4'h7;
    localparam logic [3:0] SUB_DGG_B    = 4'h8;
    localparam logic [3:0] SUB_LAM_ENABLE_MASK = 4'h9;
    localparam logic [3:0] SUB_LAM_VIEW = 4'ha;
    localparam logic [3:0] SUB_CNT_A    = 4'hb;
    localparam logic [3:0] SUB_CNT_B    = 4'hc;
    localparam logic [3:0] SUB_EXT_DLY  = 4'hd;
    localparam logic [3:0] SUB_USB_SET  = 4'he;
    localparam logic [3:0] SUB_NOTEPAD  = 4'hf;

    // ------------------------------------------------------------------
    // global mode fields
    // ------------------------------------------------------------------
    localparam int GM_LEN_LSB     = 0;
    localparam int GM_SPILL_BIT   = 3;
    localparam int GM_SHARED_BIT  = 5;
    localparam int GM_TERM_BIT    = 6;
    localparam int GM_HDR_BIT     = 8;
    localparam int GM_ARB_BIT     = 12;
    localparam logic [2:0]  LEN_SINGLE_EVENT = 3'h7;
    localparam logic [12:0] LEN_MAX_WORDS    = 13'h1000;

    // delays fields
    localparam int DLY_TRIG_LSB = 0;
    localparam int DLY_LAM_LSB  = 8;

    // firmware identifier, arbitrary digits
    localparam logic [15:0] FW_ID_DEFAULT = 16'h1234;

    // reset values, nothing documented so all clear
    localparam logic [15:0] RST_GMODE  = 16'h0000;
    localparam logic [15:0] RST_DELAYS = 16'h0000;
    localparam logic [23:0] RST_W24    = 24'h000000;
    localparam logic [31:0] RST_W32    = 32'h00000000;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS  = 10;
    localparam int SW_TRIG_NS     = 150;
    localparam int SW_TRIG_CYCLES = (SW_TRIG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int US_NS          = 1000;
    localparam int US_CYCLES      = US_NS / CLK_PERIOD_NS;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [4:0]  station;
        logic [4:0]  func;
        logic [3:0]  subaddr;
        logic [31:0] wdata;
    } ccr_cmd_t;

    typedef struct packed {
        logic        valid;
        logic        q;
        logic        x;
        logic [31:0] rdata;
    } ccr_rsp_t;

    typedef struct packed {
        logic [12:0] buffer_length_words;
        logic        single_event;
        logic        spill_across;
        logic        shared_buffer_enable;
        logic [1:0]  terminator_count;
        logic [1:0]  header_words;
        logic        arbitration_enable;
        logic [7:0]  lam_timeout_us;
    } ccr_bufcfg_t;

    typedef struct packed {
        logic [23:0] scaler_dump_control;
        logic [31:0] indicator_source_select;
        logic [31:0] output_source_select;
        logic [31:0] user_device_source_select;
        logic [31:0] pulse_generator_a_timing;
        logic [31:0] pulse_generator_b_timing;
        logic [31:0] coarse_delay_extension;
        logic [31:0] host_buffering_setup;
    } ccr_aux_t;

endpackage : ccr_pkg

// ===== logic/ccr_us_delay.sv
// microsecond delay timer: waits a programmed number of microseconds, then pulses done
// assumes start is a one-cycle pulse in the clk_i domain
`timescale 1ns/1ns
module ccr_us_delay #(
    parameter int US_CYCLES = ccr_pkg::US_CYCLES
) (
    input  wire logic       clk_i,
    input  wire logic       rst_b_i,
    input  wire logic       start_i,
    input  wire logic [7:0] delay_us_i,
    output logic            busy_o,
    output logic            done_o
);

    typedef struct packed {
        logic        busy;
        logic        done;
        logic [7:0]  us_left;
        logic [15:0] div;
    } ccr_dly_state_t;

    ccr_dly_state_t s_q;
    ccr_dly_state_t s_d;

    // ------------------------------------------------------------------
    // divider and countdown
    // ------------------------------------------------------------------
    // a restart while busy reloads the count: the latest start wins
    always_comb begin
        s_d      = s_q;
        s_d.done = 1'b0;
        if (start_i) begin
            s_d.div     = 16'h0000;
            s_d.us_left = delay_us_i;
            s_d.busy    = (delay_us_i != 8'h00);
            s_d.done    = (delay_us_i == 8'h00); // zero delay fires next cycle
        end else if (s_q.busy) begin
            if (s_q.div == 16'(US_CYCLES - 1)) begin
                s_d.div     = 16'h0000;
                s_d.us_left = s_q.us_left - 8'h01;
                if (s_q.us_left == 8'h01) begin
                    s_d.busy = 1'b0;
                    s_d.done = 1'b1;
                end
            end else begin
                s_d.div = s_q.div + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign busy_o = s_q.busy;
    assign done_o = s_q.done;

endmodule : ccr_us_delay

// ===== tb/ccr_regs_assertions.sv
// port checker for the register set: action strobes, command answers, buffer setup
// assumes it is bound onto ccr_regs and sees one clock domain
`timescale 1ns/1ns
module ccr_regs_assertions (input wire logic clk_i, input wire logic rst_b_i, input wire logic direct_wr_i,
    input wire logic [2:0] direct_target_i, input wire logic [15:0] direct_wdata_i, input wire logic cmd_valid_i,
    input wire ccr_pkg::ccr_cmd_t cmd_i, input wire logic scaler_stack_ready_i, input wire ccr_pkg::ccr_rsp_t rsp_o,
    input wire logic acquire_o, input wire logic sw_trigger_o, input wire logic clear_o,
    input wire logic scaler_dump_o, input wire ccr_pkg::ccr_bufcfg_t buf_cfg_o);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    logic wa, cw, gw, dg;
    // decode once; clear wins over a same-cycle write, so skip those
    assign wa = direct_wr_i && direct_target_i == 3'h1;
    assign cw = cmd_valid_i && cmd_i.station == 5'h19 && cmd_i.func == 5'h10;
    assign gw = cw && cmd_i.subaddr == 4'h1 && !wa;
    assign dg = wa && direct_wdata_i[4] && direct_wdata_i[0] && acquire_o && scaler_stack_ready_i;
    a_start_level: assert property (wa && !direct_wdata_i[2] |=> acquire_o == $past(direct_wdata_i[0]))
        else $error("acquire level wrong");
    a_trig_pulse: assert property (wa && direct_wdata_i[1] && !direct_wdata_i[2] |=> sw_trigger_o [*8])
        else $error("trigger pulse short");
    a_clear_pulse: assert property (wa && direct_wdata_i[2] |=> clear_o && !acquire_o ##1 !clear_o)
        else $error("clear pulse wrong");
    a_dump_gate: assert property (scaler_dump_o |-> $past(dg))
        else $error("dump without cause");
    a_rsp_valid: assert property (cmd_valid_i |=> rsp_o.valid)
        else $error("no answer");
    a_ro_write: assert property (cw && cmd_i.subaddr inside {4'h0, 4'ha, 4'hb, 4'hc, 4'hf} |=> rsp_o.x && !rsp_o.q)
        else $error("read-only write taken");
    a_gmode_flags: assert property (gw |=> buf_cfg_o.spill_across == $past(cmd_i.wdata[3])
        && buf_cfg_o.shared_buffer_enable == $past(cmd_i.wdata[5]) && buf_cfg_o.arbitration_enable == $past(cmd_i.wdata[12]))
        else $error("mode flags wrong");
    a_sep_hdr: assert property (gw |=> buf_cfg_o.terminator_count == ($past(cmd_i.wdata[6]) ? 2'h2 : 2'h1)
        && buf_cfg_o.header_words == ($past(cmd_i.wdata[8]) ? 2'h2 : 2'h1)) else $error("word counts wrong");
    a_len_code: assert property (gw && cmd_i.wdata[2:0] != 3'h7 |=>
        buf_cfg_o.buffer_length_words == 13'h1000 >> $past(cmd_i.wdata[2:0])) else $error("length wrong");
    a_lam_wait: assert property (cw && cmd_i.subaddr == 4'h2 && !wa |=>
        buf_cfg_o.lam_timeout_us == $past(cmd_i.wdata[15:8])) else $error("timeout wrong");
    cover property (scaler_dump_o);
    cover property (clear_o);
    cover property (gw ##1 buf_cfg_o.single_event);
endmodule : ccr_regs_assertions
bind ccr_regs ccr_regs_assertions u_regs_chk (.*);

// ===== tb/ccr_host_model.sv
// host partner: action writes and station commands, one at a time
// assumes one caller process; requests launch just after an edge
`timescale 1ns/1ns
module ccr_host_model (
    input  wire logic        clk_i,
    output logic             wr_o,
    output logic [15:0]      wd_o,
    output logic             cv_o,
    output ccr_pkg::ccr_cmd_t cmd_o
);
    initial begin
        wr_o = 1'b0;
        wd_o = 16'h0;
        cv_o = 1'b0;
        cmd_o = '0;
    end
    // released data is inverted so stale values never look valid
    task act(input logic [15:0] d);
        @(posedge clk_i) wr_o <= 1'b1;
        wd_o <= d;
        @(posedge clk_i) wr_o <= 1'b0;
        wd_o <= ~d;
    endtask : act
    // function 0 reads, function 16 writes
    task cmd(input logic [4:0] n, input logic [4:0] f, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i) cv_o <= 1'b1;
        cmd_o <= '{n, f, a, d};
        @(posedge clk_i) cv_o <= 1'b0;
        cmd_o <= ~cmd_o;
    endtask : cmd
endmodule : ccr_host_model

// ===== tb/tb_crate_controller_control_registers.sv
// bench for the register set: register file round trips, pseudo-registers, action strobes
// assumes the host model drives the request side
`timescale 1ns/1ns
module tb_crate_controller_control_registers;
    logic clk_i, rst_b_i = 1'b0, rdy = 1'b0, wr, cv, acq, trg, clr, dmp, rd = 1'b0, rv, evs;
    logic [2:0] tg = 3'h1;
    logic [15:0] wd, rdat;
    logic [23:0] lam = 24'h0, np = 24'h0;
    logic [31:0] ca = 32'h0, cb = 32'h0, lf, w;
    logic [34:0] ev, exp_q[$];
    logic [3:0] ws[11] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hd, 4'he};
    logic [3:0] rs[5] = '{4'h0, 4'ha, 4'hb, 4'hc, 4'hf};
    ccr_pkg::ccr_cmd_t cmd;
    ccr_pkg::ccr_rsp_t rsp;
    ccr_pkg::ccr_bufcfg_t cfg;
    int n_fail = 0, comparisons = 0;
    ccr_host_model host (.clk_i(clk_i), .wr_o(wr), .wd_o(wd), .cv_o(cv), .cmd_o(cmd));
    ccr_regs dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .direct_wr_i(wr), .direct_rd_i(rd), .direct_target_i(tg),
        .direct_wdata_i(wd), .cmd_valid_i(cv), .cmd_i(cmd), .lam_lines_i(lam), .counter_a_i(ca), .counter_b_i(cb),
        .notepad_map_i(np), .user_input_1_i(1'b0), .scaler_stack_ready_i(rdy), .direct_rd_valid_o(rv),
        .direct_rdata_o(rdat), .rsp_o(rsp), .acquire_o(acq), .sw_trigger_o(trg), .clear_o(clr), .scaler_dump_o(dmp),
        .event_start_o(evs), .buf_cfg_o(cfg), .aux_o());
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task tally_and_finish;
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : tally_and_finish
    // note {check data, q, x, data}; read-only and foreign requests refused
    task rq(input logic [4:0] n, f, input logic [3:0] a, input logic [31:0] d, e);
        logic ok;
        ok = n == 5'h19 && (f == 5'h00 || f == 5'h10);
        exp_q.push_back({!ok || f == 5'h00, ok && !(f == 5'h10 && a inside {rs}), ok, ok ? e : 32'h0});
        host.cmd(n, f, a, d);
    endtask : rq
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    // watcher: oldest note against each answer
    always @(posedge clk_i) begin
        if (rsp.valid === 1'b1) begin
            ev = exp_q.size() > 0 ? exp_q.pop_front() : 35'h0;
            chk("rsp_qx", {30'h0, ev[33:32]}, {30'h0, rsp.q, rsp.x});
            if (ev[34]) chk("rsp_rdata", ev[31:0], rsp.rdata);
        end
    end
    // limit well past the expected run of about 110 cycles
    initial begin
        #300000;
        n_fail++;
        tally_and_finish();
    end
    initial begin
        lf = 32'h0001264a;
        repeat (4) @(posedge clk_i);
        rst_b_i <= 1'b1;
        chk("len_reset", 32'h1000, {19'h0, cfg.buffer_length_words});
        foreach (ws[i]) begin
            lf = lfsr(lf);
            w = lf & (ws[i] inside {4'h1, 4'h2} ? 32'hffff : ws[i] inside {4'h3, 4'h9} ? 32'hffffff : 32'hffffffff);
            rq(5'h19, 5'h10, ws[i], lf, 32'h0);
            rq(5'h19, 5'h00, ws[i], 32'h0, w);
        end
        lam <= lf[23:0];
        ca <= ~lf;
        cb <= lf ^ 32'h5a5a5a5a;
        np <= lf[31:8];
        foreach (rs[i]) rq(5'h19, 5'h10, rs[i], 32'hffffffff, 32'h0);
        rq(5'h19, 5'h00, 4'h0, 32'h0, {16'h0, ccr_pkg::FW_ID_DEFAULT});
        rq(5'h19, 5'h00, 4'ha, 32'h0, {8'h0, lam});
        rq(5'h19, 5'h00, 4'hb, 32'h0, ca);
        rq(5'h19, 5'h00, 4'hc, 32'h0, cb);
        rq(5'h18, 5'h00, 4'h1, 32'h0, 32'h0);
        rq(5'h19, 5'h01, 4'h1, 32'h0, 32'h0);
        rdy <= 1'b1;
        host.act(16'h0009);
        #1 chk("acquire", 32'h1, {31'h0, acq});
        @(posedge clk_i) rd <= 1'b1;
        @(posedge clk_i) rd <= 1'b0;
        #1 chk("direct_rd", 32'h10001, {15'h0, rv, rdat});
        @(posedge clk_i) tg <= 3'h2;
        host.act(16'h0000);
        tg <= 3'h1;
        #1 chk("foreign_tgt", 32'h1, {31'h0, acq});
        @(posedge clk_i) lam <= 24'h0;
        @(posedge clk_i) lam <= 24'hffffff;
        @(posedge clk_i) #1 chk("lam_event", 32'h1, {31'h0, evs});
        host.act(16'h0011);
        #1 chk("dump", 32'h1, {31'h0, dmp});
        host.act(16'h0010);
        #1 chk("dump_idle", 32'h0, {31'h0, dmp});
        host.act(16'h0002);
        repeat (14) @(posedge clk_i);
        #1 chk("trig_held", 32'h1, {31'h0, trg});
        @(posedge clk_i);
        #1 chk("trig_end", 32'h0, {31'h0, trg});
        host.act(16'h0004);
        #1 chk("clear", 32'h1, {31'h0, clr});
        rq(5'h19, 5'h00, 4'h1, 32'h0, 32'h0);
        repeat (4) @(posedge clk_i);
        chk("pending", 32'h0, exp_q.size());
        tally_and_finish();
    end
endmodule : tb_crate_controller_control_registers
